// [common/lsd_params.svh]
// Purpose: constants for the segment shift/latch driver
// Assumes: 40 MHz core clock
// Notes: times in ns, cycle counts derived from them
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH
`define LSD_STAGES 120
`define LSD_SEGS 60
`define LSD_CLK_NS 25
`define LSD_FIFO_DEPTH 16
// least load high time, in ns, and in cycles (rounded up)
`define LSD_LOAD_HIGH_NS 100
`define LSD_LOAD_HIGH_CYC ((`LSD_LOAD_HIGH_NS + `LSD_CLK_NS - 1) / `LSD_CLK_NS)
`endif

// [common/lsd_pkg.sv]
// Purpose: types for the segment shift/latch driver
// Assumes: lsd_params.svh constants
// Notes: none
`include "lsd_params.svh"
package lsd_pkg;
    // common drive level: high, low or middle
    typedef enum logic [1:0] {LSD_LVL_LOW, LSD_LVL_HIGH, LSD_LVL_MID} lsd_lvl_e;
    typedef struct packed {
        lsd_lvl_e com_a;
        lsd_lvl_e com_b;
    } lsd_com_s;
    typedef enum logic {LSD_SEL_A, LSD_SEL_B} lsd_sel_e;
endpackage : lsd_pkg

// [hw/lsd_fifo.sv]
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty are exact
`timescale 1ns/10ps
`default_nettype none
module lsd_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop, full, empty;
    always_comb
    begin
        full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
        empty = (wr_reg == rd_reg);
        push = i_in_valid && !full;
        pop = i_out_ready && !empty;
        wr_next = wr_reg + (AW+1)'(push);
        rd_next = rd_reg + (AW+1)'(pop);
    end
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_reg[wr_reg[AW-1:0]] <= i_in_data;
        end
    end
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_reg[rd_reg[AW-1:0]];
endmodule : lsd_fifo
`default_nettype wire

// [hw/lsd_driver.sv]
// Purpose: serial-in segment driver: shift register, latch, drive logic
// Assumes: all pins asynchronous to i_clk, shift clock well below 20 MHz
// Notes: segment/common levels are logic codes, not analog drive
`timescale 1ns/10ps
`default_nettype none
`include "lsd_params.svh"
module lsd_driver #(
    parameter int STAGES = `LSD_STAGES,
    parameter int SEGS = `LSD_SEGS,
    parameter int FIFO_DEPTH = `LSD_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_shift_clk,
    input wire logic i_data_in,
    input wire logic i_load,
    input wire logic i_phase_ref,
    input wire logic i_dual_mode,
    input wire logic i_all_off_test,
    input wire logic i_all_on_test_input,
    output logic [SEGS-1:0] o_segment_output,
    output lsd_pkg::lsd_com_s o_com,
    output logic o_fifo_full
);
    import lsd_pkg::*;

    // two-flop synchronisers for every pin
    logic [5:0] s1_reg, s2_reg;
    logic sclk_d_reg;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            sclk_d_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= {i_shift_clk, i_data_in, i_load, i_phase_ref,
                       i_dual_mode, i_all_off_test};
            s2_reg <= s1_reg;
            sclk_d_reg <= s2_reg[5];
        end
    end
    logic on_test_s1_reg, on_test_reg;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            on_test_s1_reg <= 1'b0;
            on_test_reg <= 1'b0;
        end
        else
        begin
            on_test_s1_reg <= i_all_on_test_input;
            on_test_reg <= on_test_s1_reg;
        end
    end
    logic sclk_s, data_s, load_s, phase_s, dual_s, off_s, sclk_rise;
    assign sclk_s = s2_reg[5];
    assign data_s = s2_reg[4];
    assign load_s = s2_reg[3];
    assign phase_s = s2_reg[2];
    assign dual_s = s2_reg[1];
    assign off_s = s2_reg[0];
    assign sclk_rise = sclk_s && !sclk_d_reg;

    // sampled bits queue here; the shifter drains one per cycle, and a
    // pending load waits until every earlier bit has been shifted
    logic f_in_ready, f_out_valid, f_out_data, drain;
    lsd_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_in_valid(sclk_rise),
        .o_in_ready(f_in_ready),
        .i_in_data(data_s),
        .o_out_valid(f_out_valid),
        .i_out_ready(drain),
        .o_out_data(f_out_data)
    );

    logic [STAGES-1:0] shift_reg, shift_next;
    logic [STAGES-1:0] latch_reg, latch_next;
    logic full_reg, full_next;
    logic load_d_reg, catch_reg, catch_next;
    always_comb
    begin
        // a load that finds bits still queued lets them drain first, so
        // the latch never takes a frame short of its tail
        catch_next = catch_reg;
        if (!load_s || !f_out_valid)
        begin
            catch_next = 1'b0;
        end
        else if (!load_d_reg)
        begin
            catch_next = 1'b1;
        end
        // bits arriving during a load wait for its end; past the queue
        // depth they are lost, and the full flag tells the host so
        drain = !load_s || catch_next;
        shift_next = shift_reg;
        latch_next = latch_reg;
        full_next = !f_in_ready;
        if (drain && f_out_valid)
        begin
            shift_next = {shift_reg[STAGES-2:0], f_out_data};
        end
        if (load_s && !f_out_valid)
        begin
            latch_next = shift_reg;
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            shift_reg <= '0;
            latch_reg <= '0;
            full_reg <= 1'b0;
            load_d_reg <= 1'b0;
            catch_reg <= 1'b0;
        end
        else
        begin
            shift_reg <= shift_next;
            latch_reg <= latch_next;
            full_reg <= full_next;
            load_d_reg <= load_s;
            catch_reg <= catch_next;
        end
    end

    // common phase: in half duty the selected common alternates each frame
    // of the phase reference, swapping on its falling edge (one low half then one high half)
    logic phase_d_reg;
    lsd_sel_e sel_reg, sel_next;
    lsd_com_s com_next;
    logic [SEGS-1:0] seg_next;
    logic com_wave;
    always_comb
    begin
        sel_next = sel_reg;
        if (!dual_s)
        begin
            sel_next = LSD_SEL_A;
        end
        else if (phase_d_reg && !phase_s)
        begin
            sel_next = (sel_reg == LSD_SEL_A) ? LSD_SEL_B : LSD_SEL_A;
        end
        com_wave = phase_s;
        // commons follow the next select, so the outgoing common parks
        // at middle on the swap cycle itself instead of one late low
        // selected toggles, other mid
        if (!dual_s)
        begin
            com_next.com_a = com_wave ? LSD_LVL_HIGH : LSD_LVL_LOW;
            com_next.com_b = com_next.com_a;
        end
        else if (sel_next == LSD_SEL_A)
        begin
            com_next.com_a = com_wave ? LSD_LVL_HIGH : LSD_LVL_LOW;
            com_next.com_b = LSD_LVL_MID;
        end
        else
        begin
            com_next.com_a = LSD_LVL_MID;
            com_next.com_b = com_wave ? LSD_LVL_HIGH : LSD_LVL_LOW;
        end
    end
    genvar g;
    generate
        for (g = 0; g < SEGS; g++)
        begin : g_seg
            logic bit_on;
            // first-shifted bit ends deepest, so segment n is bit n-1
            // low half in static and with first common
            assign bit_on = (dual_s && sel_next == LSD_SEL_B) ?
                latch_reg[SEGS + g] : latch_reg[g];
            // inverse when on; tests force off or on
            assign seg_next[g] = off_s ? com_wave :
                (on_test_reg ? !com_wave : (com_wave ^ bit_on));
        end
    endgenerate
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase_d_reg <= 1'b0;
            sel_reg <= LSD_SEL_A;
            o_com <= '{LSD_LVL_MID, LSD_LVL_MID};
            o_segment_output <= '0;
            o_fifo_full <= 1'b0;
        end
        else
        begin
            phase_d_reg <= phase_s;
            sel_reg <= sel_next;
            o_com <= com_next;
            o_segment_output <= seg_next;
            o_fifo_full <= full_reg;
        end
    end
endmodule : lsd_driver
`default_nettype wire

// [test/lsd_driver_sva.sv]
// Purpose: port checks for lsd_driver
// Assumes: outputs settle within five core cycles
// Notes: levels compared as logic codes
`timescale 1ns/10ps
`default_nettype none
module lsd_driver_sva #(
    parameter int SEGS = 60
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_load,
    input wire logic i_phase_ref,
    input wire logic i_dual_mode,
    input wire logic i_all_off_test,
    input wire logic i_all_on_test_input,
    input wire logic [SEGS-1:0] o_segment_output,
    input wire lsd_pkg::lsd_com_s o_com
);
    import lsd_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    reset_mid_a: assert property (
        $rose(i_rstn) |-> o_com.com_a == LSD_LVL_MID)
        else $error("common not middle after reset");
    com_equal_a: assert property (
        (!i_dual_mode)[*5] |-> o_com.com_a == o_com.com_b)
        else $error("static commons differ");
    phase_high_a: assert property (
        (!i_dual_mode && i_phase_ref)[*5] |-> o_com.com_a == LSD_LVL_HIGH)
        else $error("common not high");
    phase_low_a: assert property (
        (!i_dual_mode && !i_phase_ref)[*5] |-> o_com.com_b == LSD_LVL_LOW)
        else $error("common not low");
    one_mid_a: assert property (
        i_dual_mode[*5] |->
        (o_com.com_a == LSD_LVL_MID) != (o_com.com_b == LSD_LVL_MID))
        else $error("half duty select wrong");
    all_off_a: assert property (
        (i_all_off_test && !i_dual_mode && i_phase_ref)[*5]
        |-> &o_segment_output) else $error("blank not in phase");
    all_lit_a: assert property (
        (i_all_on_test_input && !i_all_off_test && !i_dual_mode
        && i_phase_ref)[*5] |-> o_segment_output == '0)
        else $error("all lit not inverted");
    latch_hold_a: assert property (
        (!i_load && $stable(i_phase_ref) && $stable(i_dual_mode)
        && !i_all_off_test && !i_all_on_test_input)[*6]
        |-> $stable(o_segment_output)) else $error("latch changed");
endmodule : lsd_driver_sva
`default_nettype wire

// [test/lsd_host_model.sv]
// Purpose: host model: serial bits, shift clock, latch strobe
// Assumes: shift clock period 8 core cycles
// Notes: data line shows the inverse once released
`timescale 1ns/10ps
`default_nettype none
module lsd_host_model (
    input wire logic i_clk,
    output logic o_shift_clk,
    output logic o_data,
    output logic o_load
);
    initial
    begin
        o_shift_clk = 1'b0;
        o_data = 1'b0;
        o_load = 1'b0;
    end
    // ld 0 no strobe, 1 strobe after bits, 2 strobe held while shifting
    task automatic send(input logic [119:0] v, input int n, sl, ld);
        @(posedge i_clk);
        o_load <= (ld == 2);
        for (int i = n - 1; i >= 0; i--)
        begin
            o_data <= v[i];
            repeat (4 * sl) @(posedge i_clk);
            o_shift_clk <= 1'b1;
            repeat (4 * sl) @(posedge i_clk);
            o_shift_clk <= 1'b0;
        end
        o_data <= ~v[0];
        repeat (8) @(posedge i_clk);
        o_load <= (ld != 0);
        repeat (8) @(posedge i_clk);
        o_load <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask : send
endmodule : lsd_host_model
`default_nettype wire

// [test/lsd_driver_tb.sv]
// Purpose: self-checking bench for lsd_driver
// Assumes: 40 MHz core clock
// Notes: fifo overrun is provoked deliberately
`timescale 1ns/10ps
`default_nettype none
module lsd_driver_tb;
    import lsd_pkg::*;
    logic i_clk, i_rstn, ph, dm, af, ao, sclk, sdat, sld, full;
    logic [59:0] seg;
    logic [119:0] v;
    lsd_com_s com;
    int mismatches, cmp_count, cycles;
    lsd_host_model u_lsd_host_model (.i_clk(i_clk), .o_shift_clk(sclk),
        .o_data(sdat), .o_load(sld));
    lsd_driver u_lsd_driver (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_shift_clk(sclk), .i_data_in(sdat), .i_load(sld),
        .i_phase_ref(ph), .i_dual_mode(dm), .i_all_off_test(af),
        .i_all_on_test_input(ao), .o_segment_output(seg), .o_com(com),
        .o_fifo_full(full));
    task automatic chk(input logic [59:0] g, e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic set(input logic p, d, f, a);
        @(posedge i_clk);
        {ph, dm, af, ao} <= {p, d, f, a};
        repeat (8) @(posedge i_clk);
        #1;
    endtask : set
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic static_run;
        u_lsd_host_model.send(v, 120, 1, 1);
        set(1, 0, 0, 0);
        chk(seg, ~v[59:0]);
        set(0, 0, 0, 0);
        chk(seg, v[59:0]);
    endtask : static_run
    task automatic overrun_run;
        fork
            u_lsd_host_model.send(~v, 20, 1, 2);
            begin
                repeat (150) @(posedge i_clk);
                #1;
                chk({59'h0, full}, 60'h1);
            end
        join
        repeat (40) @(posedge i_clk);
        #1;
        chk({59'h0, full}, 60'h0);
    endtask : overrun_run
    task automatic hold_run;
        u_lsd_host_model.send(~v, 120, 1, 0);
        #1;
        chk(seg, v[59:0]);
    endtask : hold_run
    task automatic dual_run;
        u_lsd_host_model.send(v, 120, 1, 1);
        // leaving static mode, the first common is the selected one
        set(1, 1, 0, 0);
        chk({56'h0, com}, {56'h0, LSD_LVL_HIGH, LSD_LVL_MID});
        chk(seg, ~v[59:0]);
        set(0, 1, 0, 0);
        chk({56'h0, com}, {56'h0, LSD_LVL_MID, LSD_LVL_LOW});
        chk(seg, v[119:60]);
    endtask : dual_run
    task automatic test_pin_run;
        set(1, 0, 1, 0);
        chk(seg, '1);
        set(1, 0, 0, 1);
        chk(seg, '0);
        set(1, 0, 1, 1);
        chk(seg, '1);
    endtask : test_pin_run
    task automatic reset_run;
        @(posedge i_clk);
        {i_rstn, ph, dm, af, ao} <= '0;
        repeat (2) @(posedge i_clk);
        #1;
        chk({56'h0, com}, {56'h0, LSD_LVL_MID, LSD_LVL_MID});
        chk(seg, '0);
        @(posedge i_clk);
        i_rstn <= 1'b1;
        // cleared latch: every segment follows the common
        set(1, 0, 0, 0);
        chk(seg, '1);
    endtask : reset_run
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out;
        end
    end
    initial
    begin
        // test inputs low until first latch
        {i_rstn, ph, dm, af, ao, mismatches, cmp_count, cycles} = '0;
        v = {60'h0F0F0F0F0F0F0F0, 60'h123456789ABCDEF};
        repeat (9) @(posedge i_clk);
        #1;
        chk({56'h0, com}, {56'h0, LSD_LVL_MID, LSD_LVL_MID});
        @(posedge i_clk);
        i_rstn <= 1'b1;
        static_run;
        overrun_run;
        hold_run;
        dual_run;
        test_pin_run;
        reset_run;
        close_out;
    end
endmodule : lsd_driver_tb
bind lsd_driver lsd_driver_sva #(.SEGS(SEGS)) u_lsd_driver_sva (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(i_load),
    .i_phase_ref(i_phase_ref),
    .i_dual_mode(i_dual_mode),
    .i_all_off_test(i_all_off_test),
    .i_all_on_test_input(i_all_on_test_input),
    .o_segment_output(o_segment_output),
    .o_com(o_com)
);
`default_nettype wire
